// file: iso_io_pkg.sv
// Purpose: constants for the isolated i/o interrupt register bank
// Assumes: 125 MHz clk, registers in base_region_zero, one word each
// Notes: register map and field positions
//
// Notes on behaviour
// - bit 12 of control/status at 0x38 enables external interrupt service
// - writing one to bit 17 or 23 clears pending or missed flag
// - enable and polarity bits are plain read/write control bits
// - input registers are read only; writes change nothing
// - output register write sets its relays to the written bits
// - output register read returns present relay states
// - input and output registers have fixed direction, no configuration
// - enabled request edge sets pending flag and raises pci interrupt
// - edge while pending sets single missed flag, not counted
// - edges detected only while active-low gate input is low
// - bit 6 selects rising or falling request edge
package iso_io_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  OFF_INPUT_DATA   = 8'h00;
    localparam logic [7:0]  OFF_OUTPUT_DATA  = 8'h04;
    localparam logic [7:0]  OFF_INT_CTRL     = 8'h38;
    // ------------------------------------------------------------
    // fields of interrupt_control_status
    // ------------------------------------------------------------
    localparam int          BIT_POLARITY     = 6;
    localparam int          BIT_ENABLE       = 12;
    localparam int          BIT_PENDING      = 17;
    localparam int          BIT_MISSED       = 23;
    localparam logic [31:0] RESET_INT_CTRL   = 32'h0000_0000;
    localparam logic [31:0] RESET_OUTPUT     = 32'h0000_0000;
endpackage

// file: in_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input from outside the clk domain
// Notes: output changes when stages two and three agree
`timescale 1ns/10ps
module in_sync
    import iso_io_pkg::*;
#(
    parameter logic INIT = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic       next_dout;

    always_comb begin
        next_stage = {stage[1:0], din};
        next_dout  = (stage[1] == stage[2]) ? stage[2] : dout;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage <= {3{INIT}};
            dout  <= INIT;
        end else begin
            stage <= next_stage;
            dout  <= next_dout;
        end
    end
endmodule

// file: isolated_io_interrupt_regs.sv
// Purpose: interrupt control/status, input and output registers
// Assumes: simple register port in base_region_zero, single-cycle access
// Notes: relays and inputs are fixed-direction 32-bit ports
`timescale 1ns/10ps
module isolated_io_interrupt_regs
    import iso_io_pkg::*;
#(
    parameter int IO_WIDTH = 32
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic [7:0]          reg_addr,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [31:0]         reg_wdata,
    output logic      [31:0]         reg_rdata,
    input  wire logic [IO_WIDTH-1:0] input_pins,
    output logic      [IO_WIDTH-1:0] relay_out,
    input  wire logic                irq_request,
    input  wire logic                external_irq_gate_n,
    output logic                     pci_irq
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic                req_s;
    logic                gate_n_s;
    logic [IO_WIDTH-1:0] inputs_s;

    in_sync #(.INIT(1'b0)) u_req (.clk(clk), .rst_n(rst_n), .din(irq_request), .dout(req_s));
    in_sync #(.INIT(1'b1)) u_gate (.clk(clk), .rst_n(rst_n), .din(external_irq_gate_n), .dout(gate_n_s));

    genvar gi;
    generate
        for (gi = 0; gi < IO_WIDTH; gi++) begin : g_in
            in_sync #(.INIT(1'b0)) u_in (.clk(clk), .rst_n(rst_n), .din(input_pins[gi]), .dout(inputs_s[gi]));
        end
    endgenerate

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic                sel_ctrl;
    logic                sel_out;
    logic                enable;
    logic                polarity;
    logic                pending;
    logic                missed;
    logic                req_d;
    logic                edge_hit;

    // only the control and output words take writes
    always_comb begin
        sel_ctrl = reg_wr && (reg_addr == OFF_INT_CTRL);
        sel_out  = reg_wr && (reg_addr == OFF_OUTPUT_DATA);
    end

    // ------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------
    logic                next_enable;
    logic                next_polarity;

    always_comb begin
        next_enable   = sel_ctrl ? reg_wdata[BIT_ENABLE] : enable;
        next_polarity = sel_ctrl ? reg_wdata[BIT_POLARITY] : polarity;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enable   <= RESET_INT_CTRL[BIT_ENABLE];
            polarity <= RESET_INT_CTRL[BIT_POLARITY];
        end else begin
            enable   <= next_enable;
            polarity <= next_polarity;
        end
    end

    // ------------------------------------------------------------
    // request edge detection
    // ------------------------------------------------------------
    logic                next_req_d;

    always_comb begin
        next_req_d = req_s;
        // polarity 0 rising, 1 falling; detection only while enabled
        edge_hit   = !gate_n_s && enable &&
                     (polarity ? (req_d && !req_s) : (!req_d && req_s));
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_d <= 1'b0;
        end else begin
            req_d <= next_req_d;
        end
    end

    // ------------------------------------------------------------
    // pending and missed flags
    // ------------------------------------------------------------
    logic                next_pending;
    logic                next_missed;

    always_comb begin
        // zero writes leave flags alone
        next_pending = pending;
        next_missed  = missed;
        if (sel_ctrl && reg_wdata[BIT_PENDING]) begin
            next_pending = 1'b0;
        end
        if (sel_ctrl && reg_wdata[BIT_MISSED]) begin
            next_missed = 1'b0;
        end
        // missed set wins over clear; clearing a set pending wins over an edge, which sets missed
        if (edge_hit && !pending) begin
            next_pending = 1'b1;
        end
        if (edge_hit && pending) begin
            next_missed = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pending <= RESET_INT_CTRL[BIT_PENDING];
            missed  <= RESET_INT_CTRL[BIT_MISSED];
        end else begin
            pending <= next_pending;
            missed  <= next_missed;
        end
    end

    // ------------------------------------------------------------
    // relays
    // ------------------------------------------------------------
    logic [IO_WIDTH-1:0] next_relay;

    always_comb begin
        next_relay = sel_out ? reg_wdata[IO_WIDTH-1:0] : relay_out;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            relay_out <= RESET_OUTPUT[IO_WIDTH-1:0];
        end else begin
            relay_out <= next_relay;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [31:0]         next_rdata;

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                OFF_INPUT_DATA:  next_rdata[IO_WIDTH-1:0] = inputs_s;
                OFF_OUTPUT_DATA: next_rdata[IO_WIDTH-1:0] = relay_out;
                OFF_INT_CTRL: begin
                    next_rdata[BIT_POLARITY] = polarity;
                    next_rdata[BIT_ENABLE]   = enable;
                    next_rdata[BIT_PENDING]  = pending;
                    next_rdata[BIT_MISSED]   = missed;
                end
                default:         next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // pci interrupt
    // ------------------------------------------------------------
    assign pci_irq = pending && enable;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_pending_set: assert property (@(posedge clk) disable iff (!rst_n)
        edge_hit && !pending |=> pending && pci_irq == enable)
        else $error("pending not set on enabled edge");
    a_missed_set: assert property (@(posedge clk) disable iff (!rst_n)
        edge_hit && pending |=> missed)
        else $error("missed not set on edge while pending");
    a_gate_blocks: assert property (@(posedge clk) disable iff (!rst_n)
        gate_n_s && !pending && !(sel_ctrl && reg_wdata[BIT_PENDING]) |=> !pending || $past(pending))
        else $error("edge taken while gate high");
    a_ack_clears: assert property (@(posedge clk) disable iff (!rst_n)
        sel_ctrl && reg_wdata[BIT_PENDING] && !edge_hit |=> !pending)
        else $error("pending not cleared by write one");
    a_zero_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        sel_ctrl && !reg_wdata[BIT_MISSED] && missed |=> missed)
        else $error("missed cleared by zero write");
    a_enable_wr: assert property (@(posedge clk) disable iff (!rst_n)
        sel_ctrl |=> enable == $past(reg_wdata[BIT_ENABLE]))
        else $error("enable bit not written");
    a_relay_wr: assert property (@(posedge clk) disable iff (!rst_n)
        sel_out |=> relay_out == $past(reg_wdata[IO_WIDTH-1:0]))
        else $error("relays not set by write");
    a_relay_rd: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == OFF_OUTPUT_DATA |=> reg_rdata[IO_WIDTH-1:0] == $past(relay_out))
        else $error("relay read wrong");
    a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
        pci_irq |-> pending && enable)
        else $error("pci irq without pending and enable");
    a_input_ro: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == OFF_INPUT_DATA |=> relay_out == $past(relay_out))
        else $error("input write had effect");
    a_missed_hold: assert property (@(posedge clk) disable iff (!rst_n)
        missed && !(sel_ctrl && reg_wdata[BIT_MISSED]) |=> missed)
        else $error("missed flag lost without write one");
    a_pending_hold: assert property (@(posedge clk) disable iff (!rst_n)
        pending && !(sel_ctrl && reg_wdata[BIT_PENDING]) |=> pending)
        else $error("pending flag lost without write one");
    a_polarity_wr: assert property (@(posedge clk) disable iff (!rst_n)
        sel_ctrl |=> polarity == $past(reg_wdata[BIT_POLARITY]))
        else $error("polarity bit not written");
    a_ctrl_keep: assert property (@(posedge clk) disable iff (!rst_n)
        !sel_ctrl |=> $stable(enable) && $stable(polarity))
        else $error("control bits changed without write");
    a_disabled_ignores: assert property (@(posedge clk) disable iff (!rst_n)
        !enable && !pending |=> !pending)
        else $error("edge taken while service disabled");
    a_irq_drops: assert property (@(posedge clk) disable iff (!rst_n)
        sel_ctrl && reg_wdata[BIT_PENDING] && !edge_hit |=> !pci_irq)
        else $error("pci irq held after acknowledge");
    a_rise_sel: assert property (@(posedge clk) disable iff (!rst_n)
        !polarity && enable && !gate_n_s && req_s && !req_d && !pending |=> pending)
        else $error("rising edge not taken");
    a_fall_sel: assert property (@(posedge clk) disable iff (!rst_n)
        polarity && enable && !gate_n_s && !req_s && req_d && !pending |=> pending)
        else $error("falling edge not taken");
    a_wrong_edge: assert property (@(posedge clk) disable iff (!rst_n)
        (polarity ? req_s : !req_s) && !pending |=> !pending)
        else $error("edge of wrong direction taken");
    a_ctrl_rd: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == OFF_INT_CTRL |=>
        reg_rdata[BIT_ENABLE] == $past(enable) && reg_rdata[BIT_POLARITY] == $past(polarity))
        else $error("control bits read wrong");
    a_input_rd: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == OFF_INPUT_DATA |=> reg_rdata[IO_WIDTH-1:0] == $past(inputs_s))
        else $error("input read wrong");
    a_relay_keep: assert property (@(posedge clk) disable iff (!rst_n)
        !sel_out |=> $stable(relay_out))
        else $error("relays changed without output write");
    a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data not zero without read");
endmodule

// file: user_irq_src.sv
// Purpose: user circuit driving interrupt request and gate
// Assumes: levels commanded by the bench
// Notes: outputs change just after clk
`timescale 1ns/10ps
module user_irq_src (
    input  wire logic clk,
    input  wire logic gate_on,
    input  wire logic req_lvl,
    output logic      irq_request,
    output logic      external_irq_gate_n
);
    initial begin
        irq_request = 1'b0;
        external_irq_gate_n = 1'b1;
    end
    // gate low only while requests allowed
    always @(posedge clk) begin
        external_irq_gate_n <= ~gate_on;
        irq_request <= req_lvl;
    end
endmodule

// file: testbench.sv
// Purpose: self-checking bench for the interrupt register bank
// Assumes: fixed seed, registered read data one cycle after strobe
// Notes: bench acts as host, partner as user circuit
`timescale 1ns/10ps
module testbench;
    import iso_io_pkg::*;
    logic        clk, rst_n, reg_wr, reg_rd, pci_irq, gate_on, req_lvl;
    logic        irq_request, external_irq_gate_n;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, input_pins, relay_out, d;
    int          n_fail, compares;
    integer      seed;
    localparam logic [31:0] EN = 32'h1 << BIT_ENABLE;
    localparam logic [31:0] PL = 32'h1 << BIT_POLARITY;
    localparam logic [31:0] PD = 32'h1 << BIT_PENDING;
    localparam logic [31:0] MS = 32'h1 << BIT_MISSED;
    isolated_io_interrupt_regs #(.IO_WIDTH(32)) DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .input_pins(input_pins), .relay_out(relay_out), .irq_request(irq_request),
        .external_irq_gate_n(external_irq_gate_n), .pci_irq(pci_irq));
    user_irq_src partner (.clk(clk), .gate_on(gate_on), .req_lvl(req_lvl),
        .irq_request(irq_request), .external_irq_gate_n(external_irq_gate_n));
    // ------------------------------------------------------------
    // host tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] ctrl_word(input logic en, input logic pl, input logic pd, input logic ms);
        return ({31'h0, en} << BIT_ENABLE) | ({31'h0, pl} << BIT_POLARITY) |
               ({31'h0, pd} << BIT_PENDING) | ({31'h0, ms} << BIT_MISSED);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic ev(input logic lvl, input logic exp);
        req_lvl <= lvl;
        repeat (8) @(posedge clk);
        #1 chk({31'h0, pci_irq}, {31'h0, exp});
    endtask
    task automatic end_sim;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        seed = 32'h955369cb;
        n_fail = 0;
        compares = 0;
        rst_n = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata, input_pins, gate_on, req_lvl} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFF_INT_CTRL, RESET_INT_CTRL);
        chk(relay_out, RESET_OUTPUT);
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
            wr(OFF_OUTPUT_DATA, d);
            #1 chk(relay_out, d);
            rd(OFF_OUTPUT_DATA, d);
            @(posedge clk) input_pins <= ~d;
            repeat (5) @(posedge clk);
            wr(OFF_INPUT_DATA, d);
            rd(OFF_INPUT_DATA, ~d);
            rd(OFF_OUTPUT_DATA, d);
        end
        rd(8'h10, 32'h0);
        gate_on <= 1'b1;
        wr(OFF_INT_CTRL, EN | PD | MS);
        repeat (4) @(posedge clk);
        ev(1'b1, 1'b1);
        rd(OFF_INT_CTRL, EN | PD);
        ev(1'b0, 1'b1);
        ev(1'b1, 1'b1);
        ev(1'b0, 1'b1);
        ev(1'b1, 1'b1);
        wr(OFF_INT_CTRL, EN);
        rd(OFF_INT_CTRL, EN | PD | MS);
        wr(OFF_INT_CTRL, EN | PD | MS);
        #1 chk({31'h0, pci_irq}, 32'h0);
        rd(OFF_INT_CTRL, EN);
        wr(OFF_INT_CTRL, EN | PL);
        ev(1'b0, 1'b1);
        wr(OFF_INT_CTRL, EN | PL | PD);
        ev(1'b1, 1'b0);
        rd(OFF_INT_CTRL, EN | PL);
        gate_on <= 1'b0;
        wr(OFF_INT_CTRL, EN);
        repeat (4) @(posedge clk);
        ev(1'b0, 1'b0);
        ev(1'b1, 1'b0);
        rd(OFF_INT_CTRL, EN);
        gate_on <= 1'b1;
        wr(OFF_INT_CTRL, 32'h0);
        repeat (4) @(posedge clk);
        ev(1'b0, 1'b0);
        ev(1'b1, 1'b0);
        rd(OFF_INT_CTRL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            wr(OFF_INT_CTRL, d);
            rd(OFF_INT_CTRL, ctrl_word(d[BIT_ENABLE], d[BIT_POLARITY], 1'b0, 1'b0));
        end
        wr(OFF_OUTPUT_DATA, $random(seed));
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk(relay_out, RESET_OUTPUT);
        rd(OFF_INT_CTRL, RESET_INT_CTRL);
        end_sim;
    end
endmodule
